// >>> rtl/iad_pkg.sv
// Purpose: constants for the internal register window address decoder
// Assumes: 36-bit physical addresses, 64 KB register window
// Notes:   offsets are window-relative byte offsets
package iad_pkg;
	localparam int unsigned IAD_PA_W       = 36;               // physical address width
	localparam int unsigned IAD_OFS_W      = 16;               // window offset width
	localparam int unsigned IAD_BASE_W     = IAD_PA_W - IAD_OFS_W; // base field width
	localparam logic [35:0] IAD_DEF_BASE   = 36'hF_FF1F_0000;  // default window base
	localparam logic [35:0] IAD_UNC_LO     = 36'hF_FF00_0000;  // uncached segment start
	localparam logic [35:0] IAD_UNC_HI     = 36'hF_FF3F_FFFF;  // uncached segment end
	localparam logic [31:0] IAD_VIRT_LO    = 32'hFF00_0000;    // virtual alias of segment start
	localparam logic [15:0] IAD_NAND_LO    = 16'h5000;
	localparam logic [15:0] IAD_NAND_HI    = 16'h5FFF;
	localparam logic [15:0] IAD_NAND_REGLO = 16'h5000;         // first 64-bit nand register
	localparam logic [15:0] IAD_NAND_REGHI = 16'h5030;         // last 64-bit nand register
	localparam logic [15:0] IAD_SRAM_LO    = 16'h6000;
	localparam logic [15:0] IAD_SRAM_HI    = 16'h67FF;
	localparam logic [15:0] IAD_SRAM_CTL   = 16'h6000;         // 64-bit sram control register
	localparam logic [15:0] IAD_EPCI_LO    = 16'h7000;
	localparam logic [15:0] IAD_EPCI_HI    = 16'h7FFF;
	localparam logic [15:0] IAD_SDR_LO     = 16'h8000;
	localparam logic [15:0] IAD_SDR_HI     = 16'h8FFF;
	localparam logic [15:0] IAD_EBC_LO     = 16'h9000;
	localparam logic [15:0] IAD_EBC_HI     = 16'h9FFF;
	localparam logic [15:0] IAD_ECC_LO     = 16'hA000;
	localparam logic [15:0] IAD_ECC_HI     = 16'hAFFF;
	localparam logic [15:0] IAD_DMA0_LO    = 16'hB000;
	localparam logic [15:0] IAD_DMA0_HI    = 16'hB7FF;
	localparam logic [15:0] IAD_DMA1_LO    = 16'hB800;
	localparam logic [15:0] IAD_DMA1_HI    = 16'hBFFF;
	localparam logic [15:0] IAD_RSVC_LO    = 16'hC000;
	localparam logic [15:0] IAD_RSVC_HI    = 16'hCFFF;
	localparam logic [15:0] IAD_MPCI_LO    = 16'hD000;
	localparam logic [15:0] IAD_MPCI_HI    = 16'hDFFF;
	localparam logic [15:0] IAD_CFG_LO     = 16'hE000;
	localparam logic [15:0] IAD_CFG_HI     = 16'hEFFF;
	localparam logic [15:0] IAD_TIMER_0_LO    = 16'hF000;
	localparam logic [15:0] IAD_TIMER_0_HI    = 16'hF0FF;
	localparam logic [15:0] IAD_TIMER_1_LO    = 16'hF100;
	localparam logic [15:0] IAD_TIMER_1_HI    = 16'hF1FF;
	localparam logic [15:0] IAD_TIMER_2_LO    = 16'hF200;
	localparam logic [15:0] IAD_TIMER_2_HI    = 16'hF2FF;
	localparam logic [15:0] IAD_SER0_LO    = 16'hF300;
	localparam logic [15:0] IAD_SER0_HI    = 16'hF3FF;
	localparam logic [15:0] IAD_SER1_LO    = 16'hF400;
	localparam logic [15:0] IAD_SER1_HI    = 16'hF4FF;
	localparam logic [15:0] IAD_PIO_LO     = 16'hF500;
	localparam logic [15:0] IAD_PIO_HI     = 16'hF50F;
	localparam logic [15:0] IAD_IRQ_LO     = 16'hF510;
	localparam logic [15:0] IAD_IRQ_HI     = 16'hF6FF;
	localparam logic [15:0] IAD_ACL_LO     = 16'hF700;
	localparam logic [15:0] IAD_ACL_HI     = 16'hF7FF;
	localparam logic [15:0] IAD_SPI_LO     = 16'hF800;
	localparam logic [15:0] IAD_SPI_HI     = 16'hF8FF;
	localparam int unsigned IAD_NUM_UNITS  = 19;               // one-hot select width
	// transfer size codes on the request port
	localparam logic [1:0]  IAD_SZ_8       = 2'h0;
	localparam logic [1:0]  IAD_SZ_16      = 2'h1;
	localparam logic [1:0]  IAD_SZ_32      = 2'h2;
	localparam logic [1:0]  IAD_SZ_64      = 2'h3;
	// one-hot select bit positions
	localparam int unsigned IAD_U_NAND = 0;
	localparam int unsigned IAD_U_SRAM = 1;
	localparam int unsigned IAD_U_EPCI = 2;
	localparam int unsigned IAD_U_SDR  = 3;
	localparam int unsigned IAD_U_EBC  = 4;
	localparam int unsigned IAD_U_ECC  = 5;
	localparam int unsigned IAD_U_DMA0 = 6;
	localparam int unsigned IAD_U_DMA1 = 7;
	localparam int unsigned IAD_U_MPCI = 8;
	localparam int unsigned IAD_U_CFG  = 9;
	localparam int unsigned IAD_U_TIMER_0 = 10;
	localparam int unsigned IAD_U_TIMER_1 = 11;
	localparam int unsigned IAD_U_TIMER_2 = 12;
	localparam int unsigned IAD_U_SER0 = 13;
	localparam int unsigned IAD_U_SER1 = 14;
	localparam int unsigned IAD_U_PIO  = 15;
	localparam int unsigned IAD_U_IRQ  = 16;
	localparam int unsigned IAD_U_ACL  = 17;
	localparam int unsigned IAD_U_SPI  = 18;
	// source of the request
	typedef enum logic [1:0] {
		IAD_SRC_CORE,     // processor core on the internal bus
		IAD_SRC_PCI_TGT,  // external master through a pci target window
		IAD_SRC_PCI_CFG   // external host, configuration cycle in satellite mode
	} iad_src_e;
	// where a decoded request went
	typedef enum logic [2:0] {
		IAD_DST_NONE,     // nothing claimed it
		IAD_DST_REG,      // internal register window
		IAD_DST_BOOT,     // reset-vector memory
		IAD_DST_MEM,      // software-placed memory window
		IAD_DST_PCICFG    // pci configuration space
	} iad_dst_e;
endpackage : iad_pkg

// >>> rtl/iad_decode.sv
// Purpose: decode physical addresses for the internal register window and route offsets
// Assumes: one request per cycle, inputs synchronous to clk, results one cycle later
// Notes:   window placement and memory windows come from owning controllers as inputs
//          decode is combinational and registered once: answer one cycle on
//          placement inputs must stay stable while requests run
//
// Operation
// - decode full 36-bit physical address space
// - 64 KB window, default base after reset
// - also decode window at relocated base
// - both bases reach identical register offset
// - after init only window and boot mapped
// - boot memory external channel 0 or pci
// - sdram, external, pci windows placed by software
// - 32-bit virtual alias of uncached segment
// - 32-bit registers accept 32-bit transfers only
// - 64-bit registers take 64 or 32-bit halves
// - satellite mode pci configuration cycles reach registers
// - pci configuration any size, always little endian
// - pci target windows reach device resources
// - reserved offset ranges route to no unit
// - nand flash and sram controller ranges
// - 4 KB blocks for four units
// - dma controllers, main pci, configuration unit
// - timers and serial ports in 256 byte blocks
// - parallel io, interrupt, audio, spi ranges
// - nand and sram 64-bit register layout
`timescale 1ns/1ps
module iad_decode
	import iad_pkg::*;
#(
	parameter int unsigned NUM_MEM_WIN = 3 // sdram, external bus, pci initiator windows
) (
	input  wire logic                          clk,
	input  wire logic                          sys_rst,
	// request side
	input  wire logic                          req_valid,
	input  wire iad_pkg::iad_src_e             req_src,
	input  wire logic [iad_pkg::IAD_PA_W-1:0]  req_addr,
	input  wire logic [1:0]                    req_size,
	// system setup
	input  wire logic                          big_endian,
	input  wire logic                          satellite_mode,
	// placement from the owning controllers
	input  wire logic                          reloc_valid,
	input  wire logic [iad_pkg::IAD_BASE_W-1:0] reloc_base,
	input  wire logic                          boot_from_pci,
	input  wire logic [iad_pkg::IAD_PA_W-1:0]  boot_base,
	input  wire logic [iad_pkg::IAD_PA_W-1:0]  boot_mask,
	input  wire logic [NUM_MEM_WIN-1:0]        win_enable,
	input  wire logic [NUM_MEM_WIN*iad_pkg::IAD_PA_W-1:0] win_base,
	input  wire logic [NUM_MEM_WIN*iad_pkg::IAD_PA_W-1:0] win_mask,
	input  wire logic [NUM_MEM_WIN-1:0]        pci_tgt_hit,
	// answer, one cycle after the request edge
	output logic                               rsp_valid,
	output iad_pkg::iad_dst_e                  rsp_dst,
	output logic [iad_pkg::IAD_NUM_UNITS-1:0]  rsp_unit_sel,
	output logic [iad_pkg::IAD_OFS_W-1:0]      rsp_offset,
	output logic                               rsp_wide_reg,
	output logic                               rsp_upper_half,
	output logic                               rsp_size_err,
	output logic                               rsp_little_endian,
	// boot and window routing
	output logic                               rsp_boot_pci,
	output logic                               rsp_boot_ext0,
	output logic [NUM_MEM_WIN-1:0]             rsp_win_sel,
	output logic                               rsp_uncached,
	output logic [31:0]                        rsp_virt_addr
);
	import iad_pkg::*;

	// elaboration check: the window hit vector has one bit per window, at most eight
	// windows, and an empty vector would leave the memory path without a select
	if (NUM_MEM_WIN < 1 || NUM_MEM_WIN > 8) begin : g_bad_win_count
		$error("iad_decode: NUM_MEM_WIN must be 1..8");
	end

	// offset range test, used for every unit
	// both ends are inclusive
	function automatic logic in_rng(input logic [15:0] o, input logic [15:0] lo,
		input logic [15:0] hi);
		in_rng = (o >= lo) && (o <= hi);
	endfunction

	// offset to one-hot unit select; reserved offsets fall through to zero
	function automatic logic [IAD_NUM_UNITS-1:0] unit_of(input logic [15:0] o);
		logic [IAD_NUM_UNITS-1:0] s;
		s = '0;
		// ranges never overlap, so at most one bit is set
		// and no priority chain is needed
		s[IAD_U_NAND] = in_rng(o, IAD_NAND_LO, IAD_NAND_HI);
		s[IAD_U_SRAM] = in_rng(o, IAD_SRAM_LO, IAD_SRAM_HI);
		s[IAD_U_EPCI] = in_rng(o, IAD_EPCI_LO, IAD_EPCI_HI);
		s[IAD_U_SDR]  = in_rng(o, IAD_SDR_LO, IAD_SDR_HI);
		s[IAD_U_EBC]  = in_rng(o, IAD_EBC_LO, IAD_EBC_HI);
		s[IAD_U_ECC]  = in_rng(o, IAD_ECC_LO, IAD_ECC_HI);
		s[IAD_U_DMA0] = in_rng(o, IAD_DMA0_LO, IAD_DMA0_HI);
		s[IAD_U_DMA1] = in_rng(o, IAD_DMA1_LO, IAD_DMA1_HI);
		s[IAD_U_MPCI] = in_rng(o, IAD_MPCI_LO, IAD_MPCI_HI);
		s[IAD_U_CFG]  = in_rng(o, IAD_CFG_LO, IAD_CFG_HI);

		// top 4 KB is cut finer, down to 16 bytes
		s[IAD_U_TIMER_0] = in_rng(o, IAD_TIMER_0_LO, IAD_TIMER_0_HI);
		s[IAD_U_TIMER_1] = in_rng(o, IAD_TIMER_1_LO, IAD_TIMER_1_HI);
		s[IAD_U_TIMER_2] = in_rng(o, IAD_TIMER_2_LO, IAD_TIMER_2_HI);
		s[IAD_U_SER0] = in_rng(o, IAD_SER0_LO, IAD_SER0_HI);
		s[IAD_U_SER1] = in_rng(o, IAD_SER1_LO, IAD_SER1_HI);
		s[IAD_U_PIO]  = in_rng(o, IAD_PIO_LO, IAD_PIO_HI);
		s[IAD_U_IRQ]  = in_rng(o, IAD_IRQ_LO, IAD_IRQ_HI);
		s[IAD_U_ACL]  = in_rng(o, IAD_ACL_LO, IAD_ACL_HI);
		s[IAD_U_SPI]  = in_rng(o, IAD_SPI_LO, IAD_SPI_HI);
		// 0x0000-0x4fff, 0x6800-0x6fff, 0xc000-0xcfff, 0xf900+ claim nothing
		if (in_rng(o, IAD_RSVC_LO, IAD_RSVC_HI))
			s = '0;
		unit_of = s;
	endfunction

	// 64-bit registers known to this decoder: nand block and sram control
	// (0x5000-0x5037, 0x6000-0x6007); any other register counts as
	// 32 bits wide
	function automatic logic is_wide(input logic [15:0] o);
		logic nand_w;
		nand_w = in_rng(o, IAD_NAND_REGLO, IAD_NAND_REGHI + 16'h0007);
		is_wide = nand_w || ((o & 16'hFFF8) == IAD_SRAM_CTL);
	endfunction

	// next-value signals
	// recomputed every cycle, nothing carried over
	logic                     valid_nxt;
	iad_dst_e                 dst_nxt;
	logic [IAD_NUM_UNITS-1:0] sel_nxt;
	logic [IAD_OFS_W-1:0]     ofs_nxt;
	logic                     wide_nxt;
	logic                     upper_nxt;
	logic                     err_nxt;
	logic                     le_nxt;
	logic                     bpci_nxt;
	logic                     bext_nxt;
	logic [NUM_MEM_WIN-1:0]   win_nxt;
	logic                     unc_nxt;
	logic [31:0]              virt_nxt;

	// registered results
	// every output is one of these flip-flops
	logic                     valid_r;
	iad_dst_e                 dst_r;
	logic [IAD_NUM_UNITS-1:0] sel_r;
	logic [IAD_OFS_W-1:0]     ofs_r;
	logic                     wide_r;
	logic                     upper_r;
	logic                     err_r;
	logic                     le_r;
	logic                     bpci_r;
	logic                     bext_r;
	logic [NUM_MEM_WIN-1:0]   win_r;
	logic                     unc_r;
	logic [31:0]              virt_r;

	// decode of the current request
	// all given a value at the top of the decode
	logic [IAD_BASE_W-1:0] page;     // address bits above the window
	logic [IAD_OFS_W-1:0]  ofs;      // offset inside the window
	logic                  hit_def;  // default base match
	logic                  hit_rel;  // relocated base match
	logic                  hit_boot; // reset-vector region match

	// combinational decode; for core requests the register window wins over the boot region and memory windows
	always_comb begin
		// page above the window, offset inside it
		page      = req_addr[IAD_PA_W-1:IAD_OFS_W];
		ofs       = req_addr[IAD_OFS_W-1:0];
		hit_def   = (page == IAD_DEF_BASE[IAD_PA_W-1:IAD_OFS_W]);
		// relocated base counts only once marked valid
		hit_rel   = reloc_valid && (page == reloc_base);
		hit_boot  = ((req_addr & boot_mask) == (boot_base & boot_mask));
		// defaults: an unclaimed request answers with zeros, except valid, little_endian and the uncached alias
		valid_nxt = req_valid;
		dst_nxt   = IAD_DST_NONE;
		sel_nxt   = '0;
		ofs_nxt   = '0;
		wide_nxt  = 1'b0;
		upper_nxt = 1'b0;
		err_nxt   = 1'b0;
		// little endian unless the system runs big endian
		le_nxt    = ~big_endian;
		bpci_nxt  = 1'b0;
		bext_nxt  = 1'b0;
		win_nxt   = '0;
		// alias worked out for every source; only the core uses it
		unc_nxt   = (req_addr >= IAD_UNC_LO) && (req_addr <= IAD_UNC_HI);
		virt_nxt  = unc_nxt ? (IAD_VIRT_LO | {8'h00, req_addr[23:0]}) : 32'h0000_0000;
		if (!req_valid) begin
			// idle cycle: outputs return to neutral
			unc_nxt  = 1'b0;
			virt_nxt = 32'h0000_0000;
			// little_endian still mirrors the system setting
		end else if (req_src == IAD_SRC_PCI_CFG) begin
			// configuration cycles only count while the pci block is a satellite
			if (satellite_mode) begin
				dst_nxt = IAD_DST_PCICFG;
				ofs_nxt = ofs;
				le_nxt  = 1'b1;
				// byte addressable space: every size is taken
				err_nxt = 1'b0;
			end
			// as a host bridge the cycle stays unclaimed
		end else if (req_src == IAD_SRC_PCI_TGT) begin
			// target windows translate before reaching us; we only route the hit
			if (|pci_tgt_hit) begin
				dst_nxt = IAD_DST_MEM;
				win_nxt = pci_tgt_hit;
			end
			// no hit: no target window claimed the cycle
		end else if (hit_def || hit_rel) begin
			// register window wins over boot region and windows
			// both bases strip to the same offset, so they alias exactly
			dst_nxt  = IAD_DST_REG;
			ofs_nxt  = ofs;
			// reserved offsets give an empty select
			sel_nxt  = unit_of(ofs);
			wide_nxt = is_wide(ofs);
			if (wide_nxt) begin
				// 32-bit half: address bit 2 picks the word, endian flips it
				// +4 is bits 63:32 little endian, +0 big endian;
				// a 64-bit access moves both halves and sets none
				upper_nxt = (req_size == IAD_SZ_32) && (ofs[2] ^ big_endian);
				err_nxt   = (req_size != IAD_SZ_32) && (req_size != IAD_SZ_64);
			end else begin
				// 32-bit register: only a word access is defined
				err_nxt = (req_size != IAD_SZ_32) && (|sel_nxt);
			end
		end else if (hit_boot) begin
			// reset vectors: external channel 0 unless strapped for pci boot
			// only reached when the register window missed
			dst_nxt  = IAD_DST_BOOT;
			bpci_nxt = boot_from_pci;
			bext_nxt = ~boot_from_pci;
		end else begin
			// software-placed windows; none enabled out of reset
			for (int i = 0; i < NUM_MEM_WIN; i++) begin
				// masked address equals masked base; overlaps all report
				win_nxt[i] = win_enable[i] && ((req_addr & win_mask[i*IAD_PA_W +: IAD_PA_W])
					== (win_base[i*IAD_PA_W +: IAD_PA_W] & win_mask[i*IAD_PA_W +: IAD_PA_W]));
			end
			// any hit makes it a memory access
			if (|win_nxt)
				dst_nxt = IAD_DST_MEM;
		end
	end

	// registers only; reset gives a neutral answer
	// reset loads constants only, no input reaches the reset branch
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			valid_r <= 1'b0;
			dst_r   <= IAD_DST_NONE;
			sel_r   <= '0;
			ofs_r   <= '0;
			wide_r  <= 1'b0;
			upper_r <= 1'b0;
			err_r   <= 1'b0;
			le_r    <= 1'b0;
			bpci_r  <= 1'b0;
			bext_r  <= 1'b0;
			win_r   <= '0;
			unc_r   <= 1'b0;
			virt_r  <= 32'h0000_0000;
		end else begin
			// one stage, no enable: a new answer every edge
			valid_r <= valid_nxt;
			dst_r   <= dst_nxt;
			sel_r   <= sel_nxt;
			ofs_r   <= ofs_nxt;
			wide_r  <= wide_nxt;
			upper_r <= upper_nxt;
			err_r   <= err_nxt;
			le_r    <= le_nxt;
			bpci_r  <= bpci_nxt;
			bext_r  <= bext_nxt;
			win_r   <= win_nxt;
			unc_r   <= unc_nxt;
			virt_r  <= virt_nxt;
		end
	end

	// ports straight from the result flip-flops
	assign rsp_valid         = valid_r;
	assign rsp_dst           = dst_r;
	assign rsp_unit_sel      = sel_r;
	assign rsp_offset        = ofs_r;
	assign rsp_wide_reg      = wide_r;
	assign rsp_upper_half    = upper_r;
	assign rsp_size_err      = err_r;
	assign rsp_little_endian = le_r;
	assign rsp_boot_pci      = bpci_r;
	assign rsp_boot_ext0     = bext_r;
	assign rsp_win_sel       = win_r;
	assign rsp_uncached      = unc_r;
	assign rsp_virt_addr     = virt_r;

endmodule // iad_decode

// >>> verification/iad_far_model.sv
// Purpose: far-side model, the owning controllers that program window placement
// Assumes: relocation, boot and window values are static while requests run
// Notes:   pci target hits follow the same slices that the windows claim
`timescale 1ns/1ps
module iad_far_model
	import iad_pkg::*;
#(
	parameter int unsigned NUM_MEM_WIN = 3,            // window count, same as the decoder
	parameter logic [19:0] RELOC_BASE  = 20'h1_2345,   // arbitrary relocation target
	parameter logic [35:0] BOOT_BASE   = 36'h0_2000_0000 // arbitrary reset-vector region
) (
	input  wire logic                         reloc_on,
	input  wire logic                         boot_pci,
	input  wire logic                         win_on,
	input  wire iad_pkg::iad_src_e            req_src,
	input  wire logic [35:0]                  req_addr,
	output logic                              reloc_valid,
	output logic [19:0]                       reloc_base,
	output logic                              boot_from_pci,
	output logic [35:0]                       boot_base,
	output logic [35:0]                       boot_mask,
	output logic [NUM_MEM_WIN-1:0]            win_enable,
	output logic [NUM_MEM_WIN*36-1:0]         win_base,
	output logic [NUM_MEM_WIN*36-1:0]         win_mask,
	output logic [NUM_MEM_WIN-1:0]            pci_tgt_hit
);
	// placement values as software would leave them in each controller
	always_comb begin
		reloc_valid   = reloc_on;
		reloc_base    = RELOC_BASE;
		boot_from_pci = boot_pci;
		boot_base     = BOOT_BASE;
		boot_mask     = 36'hF_F000_0000;
		for (int i = 0; i < NUM_MEM_WIN; i++) begin
			// window i owns the slice whose top nibble is i+1, kept clear of the boot area
			win_enable[i]       = win_on;
			win_base[i*36+:36]  = {4'(i + 1), 32'h0000_0000};
			win_mask[i*36+:36]  = 36'hF_0000_0000;
			pci_tgt_hit[i]      = win_on && req_src == IAD_SRC_PCI_TGT
				&& req_addr[35:32] == 4'(i + 1);
		end
	end
endmodule // iad_far_model

// >>> verification/iad_decode_assertions.sv
// Purpose: concurrent checks on the register window decoder ports
// Assumes: single clock, reset active high
// Notes:   results are checked one cycle after the request edge
`timescale 1ns/1ps
module iad_decode_chk
	import iad_pkg::*;
(
	input wire logic               clk,
	input wire logic               sys_rst,
	input wire logic               req_valid,
	input wire iad_pkg::iad_src_e  req_src,
	input wire logic [35:0]        req_addr,
	input wire logic [1:0]         req_size,
	input wire logic               satellite_mode,
	input wire logic               reloc_valid,
	input wire logic [19:0]        reloc_base,
	input wire logic               rsp_valid,
	input wire iad_pkg::iad_dst_e  rsp_dst,
	input wire logic [18:0]        rsp_unit_sel,
	input wire logic [15:0]        rsp_offset,
	input wire logic               rsp_size_err,
	input wire logic               rsp_little_endian,
	input wire logic               rsp_uncached,
	input wire logic [31:0]        rsp_virt_addr
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// core request aimed at the default window
	wire core_def = req_valid && req_src == IAD_SRC_CORE && req_addr[35:16] == 20'hF_FF1F;
	a_resp_one_cycle: assert property (req_valid |=> rsp_valid)
		else $error("response missing");
	a_idle_quiet: assert property (!req_valid |=> !rsp_valid && rsp_dst == IAD_DST_NONE)
		else $error("idle cycle claimed");
	a_default_window: assert property (core_def |=> rsp_dst == IAD_DST_REG
		&& rsp_offset == $past(req_addr[15:0]))
		else $error("default window missed");
	a_reloc_alias: assert property (req_valid && req_src == IAD_SRC_CORE && reloc_valid
		&& req_addr[35:16] == reloc_base |=> rsp_dst == IAD_DST_REG
		&& rsp_offset == $past(req_addr[15:0]))
		else $error("relocated window missed");
	a_reserved_idle: assert property (rsp_dst == IAD_DST_REG && (rsp_offset < 16'h5000
		|| rsp_offset[15:12] == 4'hC || rsp_offset >= 16'hF900) |-> rsp_unit_sel == '0)
		else $error("reserved offset routed");
	a_sel_onehot: assert property ($onehot0(rsp_unit_sel))
		else $error("several units selected");
	a_timer_size: assert property (core_def && req_addr[15:11] == 5'h1E
		&& req_size != IAD_SZ_32 |=> rsp_size_err)
		else $error("bad size not flagged");
	a_cfg_refuse: assert property (req_valid && req_src == IAD_SRC_PCI_CFG && !satellite_mode
		|=> rsp_dst == IAD_DST_NONE)
		else $error("config cycle accepted");
	a_cfg_little: assert property (rsp_dst == IAD_DST_PCICFG |-> rsp_little_endian)
		else $error("config space not little endian");
	a_virt_alias: assert property (req_valid && req_addr[35:22] == 14'h3FFC |=> rsp_uncached
		&& rsp_virt_addr == {8'hFF, $past(req_addr[23:0])})
		else $error("uncached alias wrong");
	c_reg_hit: cover property (rsp_dst == IAD_DST_REG);
	c_cfg_hit: cover property (rsp_dst == IAD_DST_PCICFG);
	c_boot_hit: cover property (rsp_dst == IAD_DST_BOOT);
endmodule // iad_decode_chk

bind iad_decode iad_decode_chk u_iad_decode_chk (.clk, .sys_rst, .req_valid, .req_src,
	.req_addr, .req_size, .satellite_mode, .reloc_valid, .reloc_base, .rsp_valid, .rsp_dst,
	.rsp_unit_sel, .rsp_offset, .rsp_size_err, .rsp_little_endian, .rsp_uncached,
	.rsp_virt_addr);

// >>> verification/tb_top.sv
// Purpose: self-checking bench for the register window decoder
// Assumes: one request at a time, valid held between back-to-back requests
// Notes:   placement inputs come from the far-side model
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
	$display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_top;
	import iad_pkg::*;
	localparam logic [19:0] RB = 20'h1_2345; // arbitrary relocation target
	localparam logic [19:0] DB = IAD_DEF_BASE[35:16];
	logic clk = 0, sys_rst = 1, req_valid = 0, big_endian = 0, satellite_mode = 0;
	logic reloc_on = 0, boot_pci = 0, win_on = 0, reloc_valid, boot_from_pci;
	iad_src_e req_src = IAD_SRC_CORE;
	logic [35:0] req_addr = '0, boot_base, boot_mask;
	logic [1:0] req_size = IAD_SZ_32;
	logic [19:0] reloc_base;
	logic [2:0] win_enable, pci_tgt_hit, rsp_win_sel;
	logic [107:0] win_base, win_mask;
	iad_dst_e rsp_dst;
	logic [18:0] rsp_unit_sel;
	logic [15:0] rsp_offset;
	logic [31:0] rsp_virt_addr;
	logic rsp_valid, rsp_wide_reg, rsp_upper_half, rsp_size_err, rsp_little_endian;
	logic rsp_boot_pci, rsp_boot_ext0, rsp_uncached;
	int miscompares = 0;
	int comparisons = 0;
	always #5 clk = ~clk;
	iad_far_model #(.NUM_MEM_WIN(3), .RELOC_BASE(RB)) u_iad_far_model (.reloc_on, .boot_pci,
		.win_on, .req_src, .req_addr, .reloc_valid, .reloc_base, .boot_from_pci, .boot_base,
		.boot_mask, .win_enable, .win_base, .win_mask, .pci_tgt_hit);
	iad_decode #(.NUM_MEM_WIN(3)) u_iad_decode (.clk, .sys_rst, .req_valid, .req_src,
		.req_addr, .req_size, .big_endian, .satellite_mode, .reloc_valid, .reloc_base,
		.boot_from_pci, .boot_base, .boot_mask, .win_enable, .win_base, .win_mask,
		.pci_tgt_hit, .rsp_valid, .rsp_dst, .rsp_unit_sel, .rsp_offset, .rsp_wide_reg,
		.rsp_upper_half, .rsp_size_err, .rsp_little_endian, .rsp_boot_pci, .rsp_boot_ext0,
		.rsp_win_sel, .rsp_uncached, .rsp_virt_addr);
	// one request, result sampled just after the edge that registers it
	task automatic req(iad_src_e s, logic [35:0] a, logic [1:0] z);
		@(posedge clk);
		req_valid <= 1'b1;
		req_src <= s;
		req_addr <= a;
		req_size <= z;
		@(posedge clk);
		#1;
	endtask
	// range edges of every region, entry is offset then unit bit (FFFF for none)
	task automatic t_map();
		logic [31:0] t [29] = '{32'h4FFF_FFFF, 32'h5000_0000, 32'h5FFF_0000, 32'h6000_0001,
			32'h67FF_0001, 32'h6800_FFFF, 32'h7000_0002, 32'h8FFF_0003, 32'h9000_0004,
			32'hA000_0005, 32'hB7FF_0006, 32'hB800_0007, 32'hC000_FFFF, 32'hCFFF_FFFF,
			32'hD000_0008, 32'hE000_0009, 32'hF000_000A, 32'hF1FF_000B, 32'hF200_000C,
			32'hF300_000D, 32'hF4FF_000E, 32'hF50F_000F, 32'hF510_0010, 32'hF6FF_0010,
			32'hF700_0011, 32'hF800_0012, 32'hF8FF_0012, 32'hF900_FFFF, 32'h0000_FFFF};
		logic [18:0] e;
		foreach (t[i]) begin
			req(IAD_SRC_CORE, {DB, t[i][31:16]}, IAD_SZ_32);
			e = (t[i][15:0] == 16'hFFFF) ? 19'h0_0000 : 19'h0_0001 << t[i][4:0];
			`CHK(rsp_dst, IAD_DST_REG)
			`CHK(rsp_unit_sel, e)
			`CHK(rsp_offset, t[i][31:16])
		end
	endtask
	// same offset through the relocated base, then with relocation off
	task automatic t_alias();
		@(posedge clk);
		reloc_on <= 1'b1;
		req(IAD_SRC_CORE, {RB, 16'hB804}, IAD_SZ_32);
		`CHK(rsp_dst, IAD_DST_REG)
		`CHK(rsp_unit_sel, 19'h0_0080)
		`CHK(rsp_offset, 16'hB804)
		@(posedge clk);
		reloc_on <= 1'b0;
		req(IAD_SRC_CORE, {RB, 16'hB804}, IAD_SZ_32);
		`CHK(rsp_dst, IAD_DST_NONE)
	endtask
	// every size to a 32-bit and a 64-bit register, then halves in both byte orders
	task automatic t_size();
		for (int k = 0; k < 4; k++) begin
			req(IAD_SRC_CORE, {DB, 16'hF104}, 2'(k));
			`CHK(rsp_size_err, 2'(k) != IAD_SZ_32)
			req(IAD_SRC_CORE, {DB, 16'h6000}, 2'(k));
			`CHK(rsp_size_err, 2'(k) < IAD_SZ_32)
			`CHK(rsp_wide_reg, 1'b1)
		end
		req(IAD_SRC_CORE, {DB, 16'h5038}, IAD_SZ_32);
		`CHK(rsp_wide_reg, 1'b0)
		for (int b = 0; b < 2; b++) begin
			@(posedge clk);
			big_endian <= 1'(b);
			req(IAD_SRC_CORE, {DB, 16'h5034}, IAD_SZ_32);
			`CHK(rsp_upper_half, b == 0)
			`CHK(rsp_little_endian, b == 0)
			req(IAD_SRC_CORE, {DB, 16'h5030}, IAD_SZ_32);
			`CHK(rsp_upper_half, b == 1)
		end
	endtask
	// configuration cycles of every size on a big-endian system
	task automatic t_cfg();
		@(posedge clk);
		satellite_mode <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			req(IAD_SRC_PCI_CFG, 36'h0_0000_0010, 2'(k));
			`CHK(rsp_dst, IAD_DST_PCICFG)
			`CHK(rsp_little_endian, 1'b1)
			`CHK(rsp_size_err, 1'b0)
		end
		@(posedge clk);
		satellite_mode <= 1'b0;
		req(IAD_SRC_PCI_CFG, 36'h0_0000_0010, IAD_SZ_32);
		`CHK(rsp_dst, IAD_DST_NONE)
	endtask
	// boot region, memory windows and the uncached alias
	task automatic t_boot();
		req(IAD_SRC_CORE, 36'h0_2000_0040, IAD_SZ_32);
		`CHK(rsp_dst, IAD_DST_BOOT)
		`CHK(rsp_boot_ext0, 1'b1)
		@(posedge clk);
		boot_pci <= 1'b1;
		req(IAD_SRC_CORE, 36'h0_2000_0040, IAD_SZ_32);
		`CHK(rsp_boot_pci, 1'b1)
		`CHK(rsp_boot_ext0, 1'b0)
		req(IAD_SRC_CORE, 36'h2_0000_0100, IAD_SZ_64);
		`CHK(rsp_dst, IAD_DST_NONE)
		@(posedge clk);
		win_on <= 1'b1;
		req(IAD_SRC_CORE, 36'h2_0000_0100, IAD_SZ_64);
		`CHK(rsp_dst, IAD_DST_MEM)
		`CHK(rsp_win_sel, 3'b010)
		req(IAD_SRC_PCI_TGT, 36'h3_0000_0000, IAD_SZ_32);
		`CHK(rsp_win_sel, 3'b100)
		req(IAD_SRC_CORE, 36'hF_FF3F_FFFC, IAD_SZ_32);
		`CHK(rsp_uncached, 1'b1)
		`CHK(rsp_virt_addr, 32'hFF3F_FFFC)
		req(IAD_SRC_CORE, 36'hF_FF40_0000, IAD_SZ_32);
		`CHK(rsp_uncached, 1'b0)
	endtask
	task automatic test_done();
		$display("mismatches %0d of %0d comparisons", miscompares, comparisons);
		if (miscompares == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// main sequence, about 130 cycles
	initial begin
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		t_map();
		t_alias();
		t_size();
		t_cfg();
		t_boot();
		@(posedge clk);
		req_valid <= 1'b0;
		repeat (2) @(posedge clk);
		test_done();
	end
	// watchdog well beyond the expected run length
	initial begin
		repeat (2000) @(posedge clk);
		miscompares++;
		test_done();
	end
endmodule // tb_top
